// ---- common/mci_map.vh ----
// Register offsets, select codes, index layout and result fields of the counter read path.
`ifndef MCI_MAP_VH
`define MCI_MAP_VH

// ********************************************************************
// Register offsets
// ********************************************************************
`define MCI_OFS_SELECT     8'h6e
`define MCI_OFS_INDEX      8'h6f
`define MCI_OFS_RESULT3    8'h75
`define MCI_OFS_RESULT2    8'h76
`define MCI_OFS_RESULT1    8'h77
`define MCI_OFS_RESULT0    8'h78

// ********************************************************************
// Select codes and index layout
// ********************************************************************
`define MCI_SEL_PORT       8'h1c
`define MCI_SEL_DROP       8'h1d
`define MCI_SEL_RESET      8'h00
`define MCI_INDEX_RESET    8'h00
`define MCI_NUM_PORTS      5
`define MCI_PORT_STRIDE    8'h20
`define MCI_OFS_RX64       5'h0e
`define MCI_DROP_BASE      9'h100
`define MCI_DROP_RX_FIRST  4'h5
`define MCI_NUM_DROP       10

// ********************************************************************
// Result fields
// ********************************************************************
`define MCI_BIT_OVERFLOW   31
`define MCI_BIT_VALID      30
`define MCI_CNT_WIDTH      30
`define MCI_DROP_WIDTH     16

`endif

// ---- verilog/mci_counter_read.v ----
// Indirect read path for the per-port and dropped-packet statistics counters.
`include "mci_map.vh"
`default_nettype none

module mci_counter_read (
	// System
	input  wire        clk,
	input  wire        rst,
	// Register port
	input  wire        reg_wr,
	input  wire        reg_rd,
	input  wire [7:0]  reg_addr,
	input  wire [7:0]  reg_wdata,
	output reg  [7:0]  reg_rdata,
	// Frame events, one bit per port
	input  wire [4:0]  rx_frame_len64,
	input  wire [4:0]  tx_drop,
	input  wire [4:0]  rx_drop
);

	// ********************************************************************
	// Control registers
	// ********************************************************************
	reg  [7:0]  select_reg;
	reg  [7:0]  index_reg;
	reg  [31:0] hold_reg;
	reg  [31:0] hold_next;
	wire [149:0] len64_cnt_flat;
	wire [4:0]  len64_ovf_flat;
	wire [79:0] tx_drop_flat;
	wire [79:0] rx_drop_flat;

	// ********************************************************************
	// Address decode and counter select
	// ********************************************************************
	// One compare serves both write strobes so they always decode alike.
	function addr_is;
		input       strobe;
		input [7:0] addr;
		input [7:0] ofs;
		begin
			addr_is = strobe && (addr == ofs);
		end
	endfunction

	// Picks one 30-bit count out of the five packed per-port counts.
	function [29:0] count_of;
		input [149:0] flat;
		input [2:0]   port;
		begin
			count_of = flat[port * 30 +: 30];
		end
	endfunction

	// Drop slots 0 to 4 are transmit, 5 to 9 receive.
	function [15:0] drop_of;
		input [79:0] tx_flat;
		input [79:0] rx_flat;
		input [3:0]  slot;
		begin
			if (slot < 4'h5)
				drop_of = tx_flat[slot * 16 +: 16];
			else
				drop_of = rx_flat[(slot - 4'h5) * 16 +: 16];
		end
	endfunction

	// Byte three goes out first so the host sees overflow and valid before the count.
	function [7:0] result_byte;
		input [31:0] word;
		input [1:0]  lane;
		begin
			case (lane)
				2'h3:    result_byte = word[31:24];
				2'h2:    result_byte = word[23:16];
				2'h1:    result_byte = word[15:8];
				default: result_byte = word[7:0];
			endcase
		end
	endfunction

	wire        wr_select = addr_is(reg_wr, reg_addr, `MCI_OFS_SELECT);
	wire        trigger   = addr_is(reg_wr, reg_addr, `MCI_OFS_INDEX);
	wire        sel_port  = (select_reg == `MCI_SEL_PORT);
	wire        sel_drop  = (select_reg == `MCI_SEL_DROP);

	// Port number from index: base 0x20 per port above port zero.
	function [2:0] port_of;
		input [7:0] idx;
		begin
			port_of = idx[7:5];
		end
	endfunction

	wire [2:0]  tport     = port_of(reg_wdata);
	wire        port_hit  = trigger && sel_port && (tport < 3'h5) && (reg_wdata[4:0] == `MCI_OFS_RX64);
	wire [8:0]  drop_idx  = {1'b1, reg_wdata};
	wire        drop_hit  = trigger && sel_drop && (drop_idx < (`MCI_DROP_BASE + 9'h00a));
	wire [3:0]  dslot     = reg_wdata[3:0];

	always @(posedge clk) begin
		if (rst) begin
			select_reg <= `MCI_SEL_RESET;
			index_reg  <= `MCI_INDEX_RESET;
		end else begin
			if (wr_select)
				select_reg <= reg_wdata;
			if (trigger)
				index_reg <= reg_wdata;
		end
	end

	// ********************************************************************
	// Holding register
	// ********************************************************************
	// The snapshot keeps all four byte reads coherent while counting goes on.
	always @* begin
		hold_next = hold_reg;
		if (port_hit) begin
			hold_next = {len64_ovf_flat[tport], 1'b1, count_of(len64_cnt_flat, tport)};
		end else if (drop_hit) begin
			hold_next = {16'h0000, drop_of(tx_drop_flat, rx_drop_flat, dslot)};
		end else if (trigger) begin
			// An unknown select or index leaves the valid bit low.
			hold_next = 32'h00000000;
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			hold_reg <= 32'h00000000;
		end else begin
			hold_reg <= hold_next;
		end
	end

	// ********************************************************************
	// Counters
	// ********************************************************************
	genvar g;
	generate
		for (g = 0; g < 5; g = g + 1) begin : gen_port
			reg  [29:0] cnt_reg;
			reg         ovf_reg;
			reg  [15:0] txd_reg;
			reg  [15:0] rxd_reg;
			wire        clr = port_hit && (tport == g);
			// A frame in the clearing cycle counts as one so it is not lost.
			always @(posedge clk) begin
				if (rst) begin
					cnt_reg <= 30'h00000000;
					ovf_reg <= 1'b0;
				end else if (clr) begin
					cnt_reg <= {29'h00000000, rx_frame_len64[g]};
					ovf_reg <= 1'b0;
				end else if (rx_frame_len64[g]) begin
					cnt_reg <= cnt_reg + 30'h00000001;
					if (&cnt_reg) begin
						ovf_reg <= 1'b1;
					end
				end
			end
			// Drop counters wrap silently and are never cleared by a read.
			always @(posedge clk) begin
				if (rst) begin
					txd_reg <= 16'h0000;
				end else if (tx_drop[g]) begin
					txd_reg <= txd_reg + 16'h0001;
				end
			end
			always @(posedge clk) begin
				if (rst) begin
					rxd_reg <= 16'h0000;
				end else if (rx_drop[g]) begin
					rxd_reg <= rxd_reg + 16'h0001;
				end
			end
			// Each port owns its own slices, so every bit has one driver.
			assign len64_cnt_flat[g * 30 +: 30] = cnt_reg;
			assign len64_ovf_flat[g]            = ovf_reg;
			assign tx_drop_flat[g * 16 +: 16]   = txd_reg;
			assign rx_drop_flat[g * 16 +: 16]   = rxd_reg;
		end
	endgenerate

	// ********************************************************************
	// Read data
	// ********************************************************************
	always @(posedge clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				`MCI_OFS_SELECT:  reg_rdata <= select_reg;
				`MCI_OFS_INDEX:   reg_rdata <= index_reg;
				`MCI_OFS_RESULT3: reg_rdata <= result_byte(hold_reg, 2'h3);
				`MCI_OFS_RESULT2: reg_rdata <= result_byte(hold_reg, 2'h2);
				`MCI_OFS_RESULT1: reg_rdata <= result_byte(hold_reg, 2'h1);
				`MCI_OFS_RESULT0: reg_rdata <= result_byte(hold_reg, 2'h0);
				default:          reg_rdata <= 8'h00;
			endcase
		end
	end

endmodule

`default_nettype wire

// ---- test/mci_counter_read_asserts.sv ----
// Checker for the register port of the counter read path.
`default_nettype none
module mci_counter_read_asserts (
	// Register port
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	// The select in force at the last trigger decides the result layout.
	logic [7:0] sel_q, tsel_q, idx_q;
	wire logic rd = reg_rd && reg_addr inside {[8'h75:8'h78]};
	always_ff @(posedge clk) begin
		if (rst) begin
			{sel_q, tsel_q, idx_q} <= 24'h0;
		end else if (reg_wr && reg_addr == 8'h6e) begin
			sel_q <= reg_wdata;
		end else if (reg_wr && reg_addr == 8'h6f) begin
			{tsel_q, idx_q} <= {sel_q, reg_wdata};
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_read_holds: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("data moved");
	a_reset_clears: assert property (disable iff (1'b0) rst |=> reg_rdata == 8'h0) else $error("reset data");
	a_unmapped_zero: assert property (reg_rd && !(reg_addr inside {8'h6e, 8'h6f, [8'h75:8'h78]}) |=>
		reg_rdata == 8'h0) else $error("unmapped data");
	a_sel_readback: assert property (reg_rd && reg_addr == 8'h6e |=> reg_rdata == $past(sel_q))
		else $error("select readback");
	a_drop_upper: assert property (rd && tsel_q == 8'h1d && reg_addr < 8'h77 |=> reg_rdata == 8'h0)
		else $error("drop upper byte");
	a_valid_set: assert property (rd && reg_addr == 8'h75 && tsel_q == 8'h1c && idx_q[4:0] == 5'h0e &&
		idx_q[7:5] < 3'h5 |=> reg_rdata[6]) else $error("valid bit low");
	a_miss_invalid: assert property (rd && tsel_q == 8'h1c && idx_q[4:0] != 5'h0e |=> reg_rdata == 8'h0)
		else $error("miss data");
	a_bad_select: assert property (rd && !(tsel_q inside {8'h1c, 8'h1d}) |=> reg_rdata == 8'h0)
		else $error("bad select data");
	c_port: cover property (rd && tsel_q == 8'h1c);
	c_drop: cover property (rd && tsel_q == 8'h1d);
	c_unmapped: cover property (reg_rd && reg_addr == 8'h70);
endmodule
bind mci_counter_read mci_counter_read_asserts chk_u (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
`default_nettype wire

// ---- test/mci_host_model.sv ----
// Host model that drives the register port of the counter read path.
`default_nettype none
module mci_host_model (
	// Register port
	input  wire logic       clk,
	input  wire logic [7:0] reg_rdata,
	output var  logic       reg_wr,
	output var  logic       reg_rd,
	output var  logic [7:0] reg_addr,
	output var  logic [7:0] reg_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
	// Released address and data lines show the inverse so a stale value is never mistaken for a live one.
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		@(posedge clk) #1;
		{reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
		@(posedge clk) #1;
		{reg_wr, reg_rd, reg_addr, reg_wdata} = {2'h0, ~a, ~d};
		q = reg_rdata;
	endtask
	task automatic rdcnt(input logic [7:0] s, input logic [7:0] i, output logic [31:0] v);
		logic [7:0] q;
		acc(1'b1, 8'h6e, s, q);
		acc(1'b1, 8'h6f, i, q);
		for (int n = 0; n < 3 && (n == 0 || !v[30]); n++) acc(1'b0, 8'h75, 8'h0, v[31:24]);
		for (int b = 0; b < 3; b++) acc(1'b0, 8'(8'h76 + b), 8'h0, v[23 - 8 * b -: 8]);
	endtask
endmodule
`default_nettype wire

// ---- test/mci_counter_read_tb.sv ----
// Self-checking bench for the counter read path.
`default_nettype none
module mci_counter_read_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst = 1'b1, reg_wr, reg_rd;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [4:0] rx_frame_len64 = 5'h0, tx_drop = 5'h0, rx_drop = 5'h0;
	logic [31:0] v;
	int num_errors = 0, comparisons = 0, cyc = 0, cnt [15];
	always #2.5 clk = ~clk;
	mci_counter_read dut_u (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rx_frame_len64(rx_frame_len64), .tx_drop(tx_drop),
		.rx_drop(rx_drop));
	mci_host_model host_u (.clk(clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata));
	task automatic close_out;
		if (num_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	// Events stay quiet during reads so the reference needs no cycle timing.
	task automatic ev(input int n);
		logic [14:0] e;
		repeat (n) begin
			@(posedge clk) #1;
			e = 15'($urandom);
			{rx_drop, tx_drop, rx_frame_len64} = e;
			for (int b = 0; b < 15; b++) cnt[b] += e[b];
		end
		@(posedge clk) #1;
		{rx_drop, tx_drop, rx_frame_len64} = 15'h0;
	endtask
	always @(posedge clk) if (++cyc > 5000) begin
		num_errors++;
		close_out;
	end
	initial begin
		void'($urandom(62800));
		repeat (2) @(posedge clk);
		#1 rst = 1'b0;
		repeat (3) begin
			ev(20);
			for (int p = 0; p < 5; p++) begin
				host_u.rdcnt(8'h1c, 8'(p * 32 + 14), v);
				chk("port count", v, {2'h1, 30'(cnt[p])});
				cnt[p] = 0;
			end
			for (int p = 0; p < 10; p++) begin
				host_u.rdcnt(8'h1d, 8'(p), v);
				chk("drop count", v, {16'h0, 16'(cnt[5 + p])});
			end
		end
		host_u.rdcnt(8'h1c, 8'h0f, v);
		chk("unused offset", v, 32'h0);
		host_u.acc(1'b0, 8'h6e, 8'h0, v[7:0]);
		chk("select readback", v, 32'h1c);
		host_u.acc(1'b0, 8'h6f, 8'h0, v[7:0]);
		chk("index readback", v, 32'h0f);
		host_u.acc(1'b0, 8'h70, 8'h0, v[7:0]);
		chk("unmapped", v, 32'h0);
		host_u.rdcnt(8'h00, 8'h0e, v);
		chk("bad select", v, 32'h0);
		close_out;
	end
endmodule
`default_nettype wire
